// ==== rtl/uart_flags_pkg.sv ====
package uart_flags_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_THREE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_ONE = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_TWO = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_DATA_BUF = 8'h18;

  // ----------------------------------------
  // Status register one bit positions
  // ----------------------------------------
  localparam int S1_TX_EMPTY = 7;
  localparam int S1_TX_DONE = 6;
  localparam int S1_RX_FULL = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OVERRUN = 3;
  localparam int S1_NOISE = 2;
  localparam int S1_FRAMING = 1;
  localparam int S1_PARITY = 0;

  // ----------------------------------------
  // Status register two bit positions
  // ----------------------------------------
  localparam int S2_BREAK = 1;
  localparam int S2_RX_ACTIVE = 0;

  // ----------------------------------------
  // Control register two bit positions
  // ----------------------------------------
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE = 6;
  localparam int C2_RX_FULL_IE = 5;
  localparam int C2_IDLE_IE = 4;

  // ----------------------------------------
  // Control register three bit positions
  // ----------------------------------------
  localparam int C3_NINTH_BIT = 7;
  localparam int C3_OVERRUN_IE = 3;
  localparam int C3_NOISE_IE = 2;
  localparam int C3_FRAMING_IE = 1;
  localparam int C3_PARITY_IE = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ARM_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'b11;

endpackage

// ==== rtl/uart_status_flags_data.sv ====
// Overview of operation
// R1 - Framing error interrupts only when its enable set
// R2 - Parity error interrupts only when its enable set
// R3 - Empty flag sets on handoff, interrupts, reset-set
// R4 - Status-one read then data write clears empty
// R5 - Complete flag tracks idle transmitter, reset-set
// R6 - Complete flag plus enable requests transmit interrupt
// R7 - Full flag sets on receive transfer, interrupts
// R8 - Status-one read then data read clears full
// R9 - Idle flag sets on idle line, interrupts
// R10 - Idle needs a received character before setting
// R11 - Status-one read then data read clears idle
// R12 - Overrun flags, drops new character, keeps buffer
// R13 - Overrun clears only if seen at status read
// R14 - Software rereads status one after data read
// R15 - Noise flag sets, interrupts, read sequence clears
// R16 - Framing flag on zero stop bit, sequence clears
// R17 - Parity flag on mismatch, sequence clears
// R18 - Break sets break, framing, full; clears ninth in 9-bit mode
// R19 - Break clears by status-two sequence, rearms on ones
// R20 - Active flag sets on start sample, clears
// R21 - Data address reads receive, writes transmit
// R22 - Software avoids read-modify-write on data address
// R23 - Ninth bit captured with the received byte
// R24 - Enabled error flags form one level interrupt
`timescale 1ns/100ps
`default_nettype none

module uart_status_flags_data #(
  parameter int DATA_W = uart_flags_pkg::DATA_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [uart_flags_pkg::ADDR_W-1:0] addr_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  output logic [DATA_W-1:0] rd_data_o,
  // Receive shifter events
  input wire logic rx_enable_i,
  input wire logic nine_bit_mode_i,
  input wire logic rx_char_i,
  input wire logic [DATA_W:0] rx_data_i,
  input wire logic rx_noise_i,
  input wire logic rx_framing_err_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_break_i,
  input wire logic rx_idle_char_i,
  input wire logic rx_start_sample_i,
  input wire logic rx_false_start_i,
  input wire logic serial_receive_pin_i,
  // Transmit shifter side
  output logic [DATA_W-1:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_active_i,
  input wire logic tx_queue_i,
  // Interrupt requests
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic err_irq_o
);
  import uart_flags_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] pin_sync_q;
  logic [DATA_W-1:0] ctrl_two_q;
  logic [DATA_W-1:0] ctrl_three_q;
  logic [DATA_W-1:0] rx_buf_q;
  logic ninth_bit_q;
  logic [DATA_W-1:0] status_one;
  logic [DATA_W-1:0] status_two;
  logic [DATA_W-1:0] arm1_q;
  logic break_arm_q;
  logic tx_empty_q, tx_done_q, rx_full_q, idle_q;
  logic overrun_q, noise_q, framing_q, parity_q;
  logic break_q, rx_active_q;
  logic idle_allow_q, rx_enable_q;
  logic break_rearm_q;
  logic rd_status_one, rd_status_two, rd_data, wr_data;
  logic rx_accept, rx_overrun, break_take;
  logic [DATA_W-1:0] skid_data_q;
  logic skid_valid_q;
  logic buf_push, buf_pop, buf_in_ready;

  // Access decode
  assign rd_status_one = rd_en_i && (addr_i == ADDR_STATUS_ONE);
  assign rd_status_two = rd_en_i && (addr_i == ADDR_STATUS_TWO);
  assign rd_data = rd_en_i && (addr_i == ADDR_DATA_BUF);
  assign wr_data = wr_en_i && (addr_i == ADDR_DATA_BUF);

  // Receive event qualification
  assign break_take = rx_break_i && break_rearm_q;
  assign rx_overrun = rx_char_i && rx_full_q;
  assign rx_accept = rx_char_i && !rx_full_q;

  // Flag views
  assign status_one = {tx_empty_q, tx_done_q, rx_full_q, idle_q,
                       overrun_q, noise_q, framing_q, parity_q};
  assign status_two = {{(DATA_W-2){1'b0}}, break_q, rx_active_q};

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Line idles high, so reset to ones
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_sync_q <= SYNC_RESET;
    end else begin
      pin_sync_q <= {pin_sync_q[0], serial_receive_pin_i};
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Enables steer every interrupt request
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_two_q <= CTRL_RESET;
      ctrl_three_q <= CTRL_RESET;
    end else begin
      if (wr_en_i && (addr_i == ADDR_CTRL_TWO)) begin
        ctrl_two_q <= wr_data_i;
      end
      if (wr_en_i && (addr_i == ADDR_CTRL_THREE)) begin
        ctrl_three_q <= wr_data_i; // [R1] [R2]
      end
    end
  end

  // ----------------------------------------
  // Receive data buffer
  // ----------------------------------------
  // No reset: contents survive a system reset
  always_ff @(posedge mclk_i) begin
    if (rx_accept) begin
      rx_buf_q <= rx_data_i[DATA_W-1:0]; // [R21] [R12]
    end
    if (break_take && nine_bit_mode_i) begin
      ninth_bit_q <= 1'b0; // [R18]
    end else if (rx_accept) begin
      // Eight-bit mode mirrors bit seven
      ninth_bit_q <= nine_bit_mode_i ? rx_data_i[DATA_W] : rx_data_i[DATA_W-1]; // [R23]
    end
  end

  // ----------------------------------------
  // Clearing-sequence arming
  // ----------------------------------------
  // Each bit remembers its flag was seen set at the last status read
  for (genvar i = 0; i < DATA_W; i++) begin : g_arm
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        arm1_q[i] <= ARM_RESET[i];
      end else if (rd_status_one) begin
        arm1_q[i] <= status_one[i]; // [R13]
      end else if (rd_data || wr_data) begin
        arm1_q[i] <= 1'b0;
      end
    end
  end

  // Break arms from status two
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      break_arm_q <= 1'b0;
    end else if (rd_status_two) begin
      break_arm_q <= break_q;
    end else if (rd_data) begin
      break_arm_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit flags
  // ----------------------------------------
  // A handoff in the clearing cycle wins over the clear
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_empty_q <= 1'b1; // [R3]
    end else if (buf_pop) begin
      tx_empty_q <= 1'b1; // [R3]
    end else if (wr_data && arm1_q[S1_TX_EMPTY]) begin
      tx_empty_q <= 1'b0; // [R4]
    end
  end

  // Anything queued or shifting holds complete low
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_done_q <= 1'b1; // [R5]
    end else begin
      tx_done_q <= tx_empty_q && !tx_active_i && !tx_queue_i
                   && !tx_valid_o && !skid_valid_q; // [R5]
    end
  end

  // ----------------------------------------
  // Receive flags
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_full_q <= 1'b0;
    end else if (rx_accept || break_take) begin
      rx_full_q <= 1'b1; // [R7] [R18]
    end else if (rd_data && arm1_q[S1_RX_FULL]) begin
      rx_full_q <= 1'b0; // [R8]
    end
  end

  // Idle may set only after a character since enable or clear
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_q <= 1'b0;
      idle_allow_q <= 1'b0;
      rx_enable_q <= 1'b0;
    end else begin
      rx_enable_q <= rx_enable_i;
      if (rx_accept || break_take) begin
        idle_allow_q <= 1'b1; // [R10]
      end else if ((rx_enable_i && !rx_enable_q) || idle_q) begin
        idle_allow_q <= 1'b0; // [R10]
      end
      if (rx_idle_char_i && idle_allow_q) begin
        idle_q <= 1'b1; // [R9]
      end else if (rd_data && arm1_q[S1_IDLE]) begin
        idle_q <= 1'b0; // [R11]
      end
    end
  end

  // Error flags: set wins over the read-sequence clear
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overrun_q <= 1'b0;
      noise_q <= 1'b0;
      framing_q <= 1'b0;
      parity_q <= 1'b0;
    end else begin
      if (rx_overrun) begin
        overrun_q <= 1'b1; // [R12]
      end else if (rd_data && arm1_q[S1_OVERRUN]) begin
        overrun_q <= 1'b0; // [R13]
      end
      if (rx_noise_i) begin
        noise_q <= 1'b1; // [R15]
      end else if (rd_data && arm1_q[S1_NOISE]) begin
        noise_q <= 1'b0; // [R15]
      end
      if (rx_framing_err_i || break_take) begin
        framing_q <= 1'b1; // [R16] [R18]
      end else if (rd_data && arm1_q[S1_FRAMING]) begin
        framing_q <= 1'b0; // [R16]
      end
      if (rx_parity_err_i) begin
        parity_q <= 1'b1; // [R17]
      end else if (rd_data && arm1_q[S1_PARITY]) begin
        parity_q <= 1'b0; // [R17]
      end
    end
  end

  // ----------------------------------------
  // Break and activity flags
  // ----------------------------------------
  // A held-low line must return high before another break counts
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      break_q <= 1'b0;
      break_rearm_q <= 1'b1;
      rx_active_q <= 1'b0;
    end else begin
      if (break_take) begin
        break_q <= 1'b1; // [R18]
      end else if (rd_data && break_arm_q) begin
        break_q <= 1'b0; // [R19]
      end
      if (break_take) begin
        break_rearm_q <= 1'b0; // [R19]
      end else if (pin_sync_q[1]) begin
        break_rearm_q <= 1'b1; // [R19]
      end
      if (rx_start_sample_i) begin
        rx_active_q <= 1'b1; // [R20]
      end else if (rx_false_start_i || rx_idle_char_i) begin
        rx_active_q <= 1'b0; // [R20]
      end
    end
  end

  // ----------------------------------------
  // Transmit two-entry buffer
  // ----------------------------------------
  // Output stage plus one skid entry; a full buffer drops the write
  assign buf_in_ready = !skid_valid_q;
  assign buf_push = wr_data && buf_in_ready; // [R21]
  assign buf_pop = tx_valid_o && tx_ready_i;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= READ_ZERO;
      skid_valid_q <= 1'b0;
      skid_data_q <= READ_ZERO;
    end else if (buf_pop && skid_valid_q) begin
      tx_data_o <= skid_data_q;
      skid_valid_q <= buf_push;
      skid_data_q <= wr_data_i;
    end else if (buf_pop || !tx_valid_o) begin
      tx_valid_o <= buf_push;
      tx_data_o <= wr_data_i;
    end else if (buf_push) begin
      skid_valid_q <= 1'b1;
      skid_data_q <= wr_data_i;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Data reads return only the receive side, never the transmit side
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= READ_ZERO;
    end else if (rd_en_i) begin
      case (addr_i)
        ADDR_STATUS_ONE: rd_data_o <= status_one;
        ADDR_STATUS_TWO: rd_data_o <= status_two;
        ADDR_DATA_BUF: rd_data_o <= rx_buf_q; // [R21] [R22]
        ADDR_CTRL_TWO: rd_data_o <= ctrl_two_q;
        ADDR_CTRL_THREE: begin
          rd_data_o <= ctrl_three_q;
          rd_data_o[C3_NINTH_BIT] <= ninth_bit_q; // [R23]
        end
        default: rd_data_o <= READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  // Registered, so requests trail their flags by one cycle
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= (tx_empty_q && ctrl_two_q[C2_TX_EMPTY_IE]) // [R3]
                  || (tx_done_q && ctrl_two_q[C2_TX_DONE_IE]); // [R6]
      rx_irq_o <= (rx_full_q && ctrl_two_q[C2_RX_FULL_IE]) // [R7]
                  || (idle_q && ctrl_two_q[C2_IDLE_IE]); // [R9]
      // Break and activity flags never interrupt
      err_irq_o <= (overrun_q && ctrl_three_q[C3_OVERRUN_IE]) // [R12] [R24]
                   || (noise_q && ctrl_three_q[C3_NOISE_IE]) // [R15]
                   || (framing_q && ctrl_three_q[C3_FRAMING_IE]) // [R1]
                   || (parity_q && ctrl_three_q[C3_PARITY_IE]); // [R2]
    end
  end

endmodule // uart_status_flags_data

`default_nettype wire

// ==== verif/test_uart_status_flags_data.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_uart_status_flags_data;
  import uart_flags_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk_i = 0;
  logic sys_rst_i = 1;
  logic rd_en_i = 0, wr_en_i = 0, rx_en = 0, nine = 0, pin = 1, stall = 0;
  logic [7:0] addr_i = 0, wr_data_i = 0, rd_data_o, tx_data_o, last, cnt, d, v;
  logic [7:0] w [3];
  logic [8:0] rx_data = 0;
  logic [7:0] ev = 0; // char noise framing parity break idle start false
  logic tx_valid_o, tx_ready, tx_active, tx_queue, tx_irq_o, rx_irq_o, err_irq_o;
  int errors = 0, cmp_count = 0;
  always #5 mclk_i = ~mclk_i;
  uart_status_flags_data uut (.mclk_i, .sys_rst_i, .addr_i, .rd_en_i, .wr_en_i, .wr_data_i,
    .rd_data_o, .rx_enable_i(rx_en), .nine_bit_mode_i(nine), .rx_char_i(ev[0]),
    .rx_data_i(rx_data), .rx_noise_i(ev[1]), .rx_framing_err_i(ev[2]), .rx_parity_err_i(ev[3]),
    .rx_break_i(ev[4]), .rx_idle_char_i(ev[5]), .rx_start_sample_i(ev[6]),
    .rx_false_start_i(ev[7]), .serial_receive_pin_i(pin), .tx_data_o, .tx_valid_o,
    .tx_ready_i(tx_ready), .tx_active_i(tx_active), .tx_queue_i(tx_queue), .tx_irq_o,
    .rx_irq_o, .err_irq_o);
  tx_shifter_model shifter (.mclk_i, .sys_rst_i, .stall_i(stall), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready), .tx_active_o(tx_active),
    .tx_queue_o(tx_queue), .last_o(last), .count_o(cnt));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] bitv(input int p);
    return 8'h01 << p;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge mclk_i);
    rd_en_i = 1;
    addr_i = a;
    @(negedge mclk_i);
    rd_en_i = 0;
    q = rd_data_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge mclk_i);
    wr_en_i = 1;
    addr_i = a;
    wr_data_i = x;
    @(negedge mclk_i);
    wr_en_i = 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, d);
    check(d & m, e);
  endtask
  // One-cycle event pulses on the receive side
  task automatic pulse(input logic [7:0] m);
    @(negedge mclk_i);
    ev = m;
    @(negedge mclk_i);
    ev = 0;
  endtask
  task automatic wait_cnt(input logic [7:0] n);
    for (int i = 0; i < 40 && cnt != n; i++) @(negedge mclk_i);
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    errors++;
    finish_test;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h37ae89f1));
    repeat (12) @(negedge mclk_i);
    sys_rst_i = 0;
    rchk(ADDR_STATUS_ONE, 8'hff, 8'hc0);
    rchk(ADDR_STATUS_TWO, 8'h03, 8'h00);
    rchk(8'h00, 8'hff, 8'h00);
    // Stalled shifter: fill the buffer past its two entries
    stall = 1;
    rx_en = 1;
    wr(ADDR_CTRL_TWO, 8'hf0);
    rd(ADDR_STATUS_ONE, d);
    for (int i = 0; i < 3; i++) begin
      w[i] = 8'($urandom);
      wr(ADDR_DATA_BUF, w[i]);
    end
    rchk(ADDR_STATUS_ONE, 8'hc0, 8'h00);
    check(8'(tx_irq_o), 8'h00);
    stall = 0;
    wait_cnt(8'h01);
    check(last, w[0]);
    wait_cnt(8'h02);
    check(last, w[1]);
    repeat (20) @(negedge mclk_i);
    check(cnt, 8'h02);
    rchk(ADDR_STATUS_ONE, 8'hc0, 8'hc0);
    check(8'(tx_irq_o), 8'h01);
    // Random characters through the clearing sequence
    repeat (4) begin
      v = 8'($urandom);
      rx_data = {1'b0, v};
      pulse(8'h01);
      rchk(ADDR_STATUS_ONE, bitv(S1_RX_FULL), bitv(S1_RX_FULL));
      rchk(ADDR_DATA_BUF, 8'hff, v);
      rchk(ADDR_STATUS_ONE, bitv(S1_RX_FULL), 8'h00);
    end
    // Enables still at reset value; ninth bit is defined by now
    rchk(ADDR_CTRL_THREE, 8'h0f, 8'h00);
    wr(ADDR_CTRL_THREE, bitv(C3_OVERRUN_IE));
    // Overrun arriving between status read and data read
    pulse(8'h01);
    rd(ADDR_STATUS_ONE, d);
    rx_data = ~rx_data;
    pulse(8'h01);
    rchk(ADDR_DATA_BUF, 8'hff, v);
    check(8'(err_irq_o), 8'h01);
    rchk(ADDR_STATUS_ONE, bitv(S1_OVERRUN), bitv(S1_OVERRUN));
    rchk(ADDR_DATA_BUF, 8'hff, v);
    rchk(ADDR_STATUS_ONE, 8'h28, 8'h00);
    check(8'(err_irq_o), 8'h00);
    // Noise, framing, parity: masked, then enabled
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL_THREE, 8'h00);
      pulse(8'h02 << k);
      rchk(ADDR_STATUS_ONE, 8'h07, bitv(2 - k));
      check(8'(err_irq_o), 8'h00);
      rd(ADDR_DATA_BUF, d);
      wr(ADDR_CTRL_THREE, bitv(2 - k));
      pulse(8'h02 << k);
      @(negedge mclk_i);
      check(8'(err_irq_o), 8'h01);
      rchk(ADDR_STATUS_ONE, 8'h07, bitv(2 - k));
      rd(ADDR_DATA_BUF, d);
      @(negedge mclk_i);
      check(8'(err_irq_o), 8'h00);
    end
    // Idle gating after receiver enable rise and after clearing
    rx_en = 0;
    @(negedge mclk_i);
    rx_en = 1;
    pulse(8'h20);
    rchk(ADDR_STATUS_ONE, bitv(S1_IDLE), 8'h00);
    pulse(8'h01);
    pulse(8'h20);
    rchk(ADDR_STATUS_ONE, 8'h30, 8'h30);
    check(8'(rx_irq_o), 8'h01);
    rd(ADDR_DATA_BUF, d);
    pulse(8'h20);
    rchk(ADDR_STATUS_ONE, bitv(S1_IDLE), 8'h00);
    // Reception in progress
    pulse(8'h40);
    rchk(ADDR_STATUS_TWO, bitv(S2_RX_ACTIVE), bitv(S2_RX_ACTIVE));
    pulse(8'h80);
    rchk(ADDR_STATUS_TWO, bitv(S2_RX_ACTIVE), 8'h00);
    pulse(8'h40);
    pulse(8'h20);
    rchk(ADDR_STATUS_TWO, bitv(S2_RX_ACTIVE), 8'h00);
    // Ninth bit, then break in 9-bit mode
    nine = 1;
    rx_data = {1'b1, 8'($urandom)};
    pulse(8'h01);
    rchk(ADDR_CTRL_THREE, 8'h80, 8'h80);
    rd(ADDR_STATUS_ONE, d);
    rd(ADDR_DATA_BUF, d);
    pin = 0;
    repeat (3) @(negedge mclk_i);
    pulse(8'h10);
    rchk(ADDR_STATUS_TWO, bitv(S2_BREAK), bitv(S2_BREAK));
    rchk(ADDR_STATUS_ONE, 8'h22, 8'h22);
    rchk(ADDR_CTRL_THREE, 8'h80, 8'h00);
    rd(ADDR_DATA_BUF, d);
    rchk(ADDR_STATUS_TWO, bitv(S2_BREAK), 8'h00);
    pulse(8'h10);
    rchk(ADDR_STATUS_TWO, bitv(S2_BREAK), 8'h00);
    pin = 1;
    repeat (4) @(negedge mclk_i);
    pin = 0;
    repeat (3) @(negedge mclk_i);
    pulse(8'h10);
    rchk(ADDR_STATUS_TWO, bitv(S2_BREAK), bitv(S2_BREAK));
    finish_test;
  end
endmodule // test_uart_status_flags_data
`default_nettype wire

// ==== verif/tx_shifter_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module tx_shifter_model #(
  parameter int BUSY_CYC = 6
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Word link
  input wire logic stall_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // Shifter state
  output logic tx_active_o,
  output logic tx_queue_o,
  // Observation
  output logic [7:0] last_o,
  output logic [7:0] count_o
);
  logic [3:0] busy_q;
  // Slow shifter: takes one word, then stays busy for a whole frame
  assign tx_ready_o = !stall_i && busy_q == 4'h0;
  assign tx_active_o = busy_q != 4'h0;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 4'h0;
      tx_queue_o <= 1'b0;
      last_o <= 8'h00;
      count_o <= 8'h00;
    end else begin
      tx_queue_o <= tx_valid_i && tx_ready_o;
      if (tx_valid_i && tx_ready_o) begin
        busy_q <= 4'(BUSY_CYC);
        last_o <= tx_data_i;
        count_o <= count_o + 8'h01;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end
    end
  end
endmodule // tx_shifter_model
`default_nettype wire

// ==== verif/uart_flags_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module uart_flags_sva
  import uart_flags_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  // Receive events
  input wire logic rx_char_i,
  input wire logic rx_noise_i,
  input wire logic rx_framing_err_i,
  input wire logic rx_parity_err_i,
  // Transmit side and requests
  input wire logic [DATA_W-1:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic err_irq_o
);
  // ----------------------------------------
  // Enable mirrors
  // ----------------------------------------
  logic [7:0] ctl2_q;
  logic [7:0] ctl3_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of the enable bits, so irqs can be judged from the ports alone
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl2_q <= 8'h00;
      ctl3_q <= 8'h00;
    end else if (wr_en_i) begin
      if (addr_i == ADDR_CTRL_TWO) ctl2_q <= wr_data_i[7:0] & 8'hf0;
      if (addr_i == ADDR_CTRL_THREE) ctl3_q <= wr_data_i[7:0] & 8'h0f;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence take_s;
    tx_valid_o && tx_ready_i;
  endsequence
  sequence load_s;
    wr_en_i && addr_i == ADDR_DATA_BUF && !tx_valid_o;
  endsequence
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit word changed while stalled");
  tx_load_a: assert property (load_s |=> tx_valid_o && tx_data_o == $past(wr_data_i))
    else $error("written word not offered");
  empty_irq_a: assert property (take_s ##1 ctl2_q[C2_TX_EMPTY_IE] |=> tx_irq_o)
    else $error("no transmit request after handoff");
  tx_mask_a: assert property (ctl2_q[7:6] == 2'b00 |=> !tx_irq_o)
    else $error("transmit request while disabled");
  rx_mask_a: assert property (ctl2_q[5:4] == 2'b00 |=> !rx_irq_o)
    else $error("receive request while disabled");
  full_irq_a: assert property (rx_char_i ##1 ctl2_q[C2_RX_FULL_IE] |=> rx_irq_o)
    else $error("no receive request after character");
  err_mask_a: assert property (ctl3_q[3:0] == 4'h0 |=> !err_irq_o)
    else $error("error request while disabled");
  fe_irq_a: assert property (rx_framing_err_i ##1 ctl3_q[C3_FRAMING_IE] |=> err_irq_o)
    else $error("no request from framing error");
  pe_irq_a: assert property (rx_parity_err_i ##1 ctl3_q[C3_PARITY_IE] |=> err_irq_o)
    else $error("no request from parity error");
  noise_irq_a: assert property (rx_noise_i ##1 ctl3_q[C3_NOISE_IE] |=> err_irq_o)
    else $error("no request from noise");
  rd_hold_a: assert property (!rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without a read");
endmodule // uart_flags_sva

bind uart_status_flags_data uart_flags_sva #(.DATA_W(DATA_W)) checker_i (.mclk_i, .sys_rst_i,
  .addr_i, .rd_en_i, .wr_en_i, .wr_data_i, .rd_data_o, .rx_char_i, .rx_noise_i,
  .rx_framing_err_i, .rx_parity_err_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .tx_irq_o,
  .rx_irq_o, .err_irq_o);
`default_nettype wire
